// ### include/fhp_pkg.sv
// Package: constants for the processor-side FPGA configuration and register port controller
package fhp_pkg;
    // ------------------------------------------------------------
    // AXI4-Lite register offsets (controller's own registers)
    // ------------------------------------------------------------
    localparam logic [7:0] FHP_REG_CTRL = 8'h00;
    localparam logic [7:0] FHP_REG_STATUS = 8'h04;
    localparam logic [7:0] FHP_REG_CFG_DATA = 8'h08;
    localparam logic [7:0] FHP_REG_ACCESS = 8'h0c;
    localparam logic [7:0] FHP_REG_RDATA = 8'h10;
    localparam logic [7:0] FHP_REG_WIN_BASE = 8'h80;
    localparam logic [7:0] FHP_WIN_MASK = 8'h80;
    localparam int FHP_WIN_WORDS = 32;
    // Control bits
    localparam int FHP_CTRL_PROG_BIT = 0;
    localparam int FHP_CTRL_OSC_BIT = 1;
    // Access register fields
    localparam int FHP_ACC_DATA_LSB = 0;
    localparam int FHP_ACC_IDX_LSB = 16;
    localparam int FHP_ACC_READ_BIT = 24;
    // Status bits
    localparam int FHP_ST_BUSY_BIT = 0;
    localparam int FHP_ST_INIT_BIT = 1;
    localparam int FHP_ST_DONE_BIT = 2;
    localparam int FHP_ST_CFG_READY_BIT = 3;
    localparam int FHP_ST_IRQ_LSB = 4;
    localparam int FHP_ST_WAIT_BIT = 7;
    // ------------------------------------------------------------
    // External bus geometry
    // ------------------------------------------------------------
    localparam int FHP_DATA_W = 16;
    localparam int FHP_CFG_W = 8;
    localparam int FHP_IDX_W = 5;
    localparam logic [31:0] FHP_SPACE_BASE = 32'h46000000;
    localparam logic [31:0] FHP_SPACE_LAST = 32'h47ffffff;
    // ------------------------------------------------------------
    // Timing (bus cycles of the 100 MHz controller clock)
    // ------------------------------------------------------------
    localparam int FHP_CLK_NS = 10;
    localparam int FHP_SETUP_CYC = 2;
    localparam int FHP_STROBE_CYC = 4;
    localparam int FHP_HOLD_CYC = 2;
    localparam int FHP_TURN_CYC = 2;
    localparam int FHP_PROG_LOW_NS = 300;
    localparam int FHP_PROG_LOW_CYC = (FHP_PROG_LOW_NS + FHP_CLK_NS - 1) / FHP_CLK_NS;
    localparam int FHP_INIT_WAIT_MS = 5;
    localparam int FHP_INIT_WAIT_CYC_DEF = (FHP_INIT_WAIT_MS * 1000000) / FHP_CLK_NS;
    localparam int FHP_CNT_W = 20;
    typedef enum {FHP_IDLE, FHP_SETUP, FHP_STROBE, FHP_HOLD, FHP_TURN} fhp_bus_state_t;
    typedef enum {FHP_CFG_IDLE, FHP_CFG_PULSE, FHP_CFG_WAIT, FHP_CFG_READY} fhp_cfg_state_t;
endpackage

// ### logic/fhp_shadow_mem.sv
// Shadow memory of the 32 remote 16-bit registers, registered read data
`timescale 1ns/1ps
module fhp_shadow_mem import fhp_pkg::*; (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [FHP_IDX_W-1:0] waddr_in,
    input wire logic [FHP_DATA_W-1:0] wdata_in,
    input wire logic [FHP_IDX_W-1:0] raddr_in,
    output logic [FHP_DATA_W-1:0] rdata_out
);
    logic [FHP_DATA_W-1:0] mem [FHP_WIN_WORDS];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule

// ### logic/fhp_host_port.sv
// Processor-side controller: FPGA configuration and 32-register async bus access
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module fhp_host_port import fhp_pkg::*; #(
    parameter int INIT_WAIT_CYC = FHP_INIT_WAIT_CYC_DEF
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // External memory bus to the FPGA
    output logic FPGA_CHIP_SELECT_N_OUT,
    output logic BUS_WRITE_STROBE_N_OUT,
    output logic BUS_OUTPUT_ENABLE_N_OUT,
    output logic BUS_READ_NOT_WRITE_OUT,
    output logic [3:0] BUS_ADDR_OUT,
    output logic BANK_ADDR_BIT_OUT,
    input wire logic [FHP_DATA_W-1:0] BUS_DATA_IN,
    output logic [FHP_DATA_W-1:0] BUS_DATA_OUT,
    output logic BUS_DATA_OE_OUT,
    // Configuration and GPIO lines
    output logic PROC_GPIO_PROGRAM_OUT,
    input wire logic PROC_GPIO_INIT_IN,
    input wire logic PROC_GPIO_DONE_IN,
    output logic PROC_GPIO_OSC_ENABLE_OUT,
    input wire logic PROC_IRQ_LINE_A_IN,
    input wire logic PROC_IRQ_LINE_B_IN,
    input wire logic PROC_IRQ_LINE_C_IN
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 5 + FHP_DATA_W;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic init_s, done_s;
    logic [2:0] irq_s;
    logic [FHP_DATA_W-1:0] data_s;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {BUS_DATA_IN, PROC_IRQ_LINE_C_IN, PROC_IRQ_LINE_B_IN,
                       PROC_IRQ_LINE_A_IN, PROC_GPIO_DONE_IN, PROC_GPIO_INIT_IN};
            sync_b <= sync_a;
        end
    end
    assign init_s = sync_b[0];
    assign done_s = sync_b[1];
    assign irq_s = sync_b[4:2];
    assign data_s = sync_b[NSYNC-1:5];

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic prog_req, osc_en;
    logic aw_done, w_done;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_go;
    logic bus_busy;
    logic bus_start;
    logic bus_is_read;
    logic bus_is_cfg;
    logic [FHP_IDX_W-1:0] bus_idx;
    logic [FHP_DATA_W-1:0] bus_wdata;
    fhp_cfg_state_t cfg_state;

    function automatic logic is_win(input logic [7:0] a);
        return (a & FHP_WIN_MASK) == FHP_REG_WIN_BASE;
    endfunction

    function automatic logic [FHP_IDX_W-1:0] win_idx(input logic [7:0] a);
        return a[FHP_IDX_W+1:2];
    endfunction

    // Write held until the bus engine is free; AW and W taken in either order
    assign S_AXI_AWREADY_OUT = !aw_done && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT = !w_done && !S_AXI_BVALID_OUT;
    assign wr_go = aw_done && w_done && !S_AXI_BVALID_OUT && !bus_busy;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            aw_done <= 1'b0;
            w_done <= 1'b0;
            awaddr <= '0;
            wdata <= '0;
            wstrb <= '0;
            S_AXI_BVALID_OUT <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                aw_done <= 1'b1;
                awaddr <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                w_done <= 1'b1;
                wdata <= S_AXI_WDATA_IN;
                wstrb <= S_AXI_WSTRB_IN;
            end
            if (wr_go) begin
                aw_done <= 1'b0;
                w_done <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
            end else if (S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end
    end
    assign S_AXI_BRESP_OUT = 2'h0;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prog_req <= 1'b0;
            osc_en <= 1'b0;
        end else begin
            prog_req <= 1'b0;
            if (wr_go && awaddr == FHP_REG_CTRL && wstrb[0]) begin
                prog_req <= wdata[FHP_CTRL_PROG_BIT];
                osc_en <= wdata[FHP_CTRL_OSC_BIT];
            end
        end
    end
    assign PROC_GPIO_OSC_ENABLE_OUT = osc_en;

    // ------------------------------------------------------------
    // Configuration sequencer
    // ------------------------------------------------------------
    logic [FHP_CNT_W-1:0] cfg_cnt;
    logic prog_line;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg_state <= FHP_CFG_IDLE;
            cfg_cnt <= '0;
            prog_line <= 1'b0;
        end else begin
            case (cfg_state)
                FHP_CFG_IDLE: begin
                    prog_line <= 1'b1;
                    if (prog_req) begin
                        cfg_state <= FHP_CFG_PULSE;
                        prog_line <= 1'b0;
                        cfg_cnt <= '0;
                    end
                end
                FHP_CFG_PULSE: begin
                    cfg_cnt <= cfg_cnt + 1'b1;
                    if (cfg_cnt == FHP_CNT_W'(FHP_PROG_LOW_CYC - 1)) begin
                        prog_line <= 1'b1;
                        cfg_cnt <= '0;
                        cfg_state <= FHP_CFG_WAIT;
                    end
                end
                FHP_CFG_WAIT: begin
                    cfg_cnt <= cfg_cnt + 1'b1;
                    if (init_s || cfg_cnt == FHP_CNT_W'(INIT_WAIT_CYC - 1)) begin
                        cfg_state <= FHP_CFG_READY;
                    end
                end
                FHP_CFG_READY: begin
                    if (prog_req) begin
                        cfg_state <= FHP_CFG_PULSE;
                        prog_line <= 1'b0;
                        cfg_cnt <= '0;
                    end
                end
                default: cfg_state <= FHP_CFG_IDLE;
            endcase
        end
    end
    assign PROC_GPIO_PROGRAM_OUT = prog_line;

    // ------------------------------------------------------------
    // Bus request decode
    // ------------------------------------------------------------
    logic rd_pend;
    logic rd_done;
    logic [7:0] araddr;
    logic [FHP_DATA_W-1:0] last_rd;
    logic rd_from_mem;
    logic mem_we;
    logic [FHP_DATA_W-1:0] mem_rdata;

    always_comb begin
        bus_start = 1'b0;
        bus_is_read = 1'b0;
        bus_is_cfg = 1'b0;
        bus_idx = '0;
        bus_wdata = '0;
        if (wr_go && awaddr == FHP_REG_CFG_DATA) begin
            bus_start = 1'b1;
            bus_is_cfg = 1'b1;
            bus_wdata = {{(FHP_DATA_W-FHP_CFG_W){1'b0}}, wdata[FHP_CFG_W-1:0]};
        end else if (wr_go && awaddr == FHP_REG_ACCESS) begin
            bus_start = 1'b1;
            bus_is_read = wdata[FHP_ACC_READ_BIT];
            bus_idx = wdata[FHP_ACC_IDX_LSB +: FHP_IDX_W];
            bus_wdata = wdata[FHP_ACC_DATA_LSB +: FHP_DATA_W];
        end else if (wr_go && is_win(awaddr)) begin
            bus_start = 1'b1;
            bus_idx = win_idx(awaddr);
            bus_wdata = wdata[FHP_DATA_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Asynchronous bus engine
    // ------------------------------------------------------------
    fhp_bus_state_t bus_state;
    logic [2:0] phase_cnt;
    logic cur_read;
    logic last_read;
    logic [FHP_IDX_W-1:0] cur_idx;
    logic [FHP_DATA_W-1:0] cur_wdata;

    assign bus_busy = bus_state != FHP_IDLE;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bus_state <= FHP_IDLE;
            phase_cnt <= '0;
            cur_read <= 1'b0;
            last_read <= 1'b0;
            cur_idx <= '0;
            cur_wdata <= '0;
            last_rd <= '0;
            mem_we <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            phase_cnt <= phase_cnt + 1'b1;
            case (bus_state)
                FHP_IDLE: begin
                    if (bus_start) begin
                        cur_read <= bus_is_read;
                        cur_idx <= bus_is_cfg ? '0 : bus_idx;
                        cur_wdata <= bus_wdata;
                        phase_cnt <= '0;
                        // Direction change needs the turnaround gap first
                        bus_state <= (bus_is_read != last_read) ? FHP_TURN : FHP_SETUP;
                    end
                end
                FHP_TURN: begin
                    if (phase_cnt == 3'(FHP_TURN_CYC - 1)) begin
                        phase_cnt <= '0;
                        bus_state <= FHP_SETUP;
                    end
                end
                FHP_SETUP: begin
                    if (phase_cnt == 3'(FHP_SETUP_CYC - 1)) begin
                        phase_cnt <= '0;
                        bus_state <= FHP_STROBE;
                    end
                end
                FHP_STROBE: begin
                    if (phase_cnt == 3'(FHP_STROBE_CYC - 1)) begin
                        phase_cnt <= '0;
                        bus_state <= FHP_HOLD;
                        if (cur_read) begin
                            last_rd <= data_s;
                        end
                    end
                end
                FHP_HOLD: begin
                    if (phase_cnt == 3'(FHP_HOLD_CYC - 1)) begin
                        bus_state <= FHP_IDLE;
                        last_read <= cur_read;
                        mem_we <= cur_read;
                    end
                end
                default: bus_state <= FHP_IDLE;
            endcase
        end
    end

    // Pins: select spans setup..hold, strobe only in strobe phase
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            FPGA_CHIP_SELECT_N_OUT <= 1'b1;
            BUS_WRITE_STROBE_N_OUT <= 1'b1;
            BUS_OUTPUT_ENABLE_N_OUT <= 1'b1;
            BUS_READ_NOT_WRITE_OUT <= 1'b1;
            BUS_ADDR_OUT <= '0;
            BANK_ADDR_BIT_OUT <= 1'b0;
            BUS_DATA_OUT <= '0;
            BUS_DATA_OE_OUT <= 1'b0;
        end else begin
            FPGA_CHIP_SELECT_N_OUT <= !(bus_state inside {FHP_SETUP, FHP_STROBE, FHP_HOLD});
            BUS_WRITE_STROBE_N_OUT <= !(bus_state == FHP_STROBE && !cur_read);
            BUS_OUTPUT_ENABLE_N_OUT <= !(bus_state == FHP_STROBE && cur_read);
            // Read level stays for the whole cycle so the FPGA read gate covers it
            BUS_READ_NOT_WRITE_OUT <= (bus_state == FHP_IDLE) || cur_read;
            BUS_ADDR_OUT <= cur_idx[3:0];
            BANK_ADDR_BIT_OUT <= cur_idx[FHP_IDX_W-1];
            BUS_DATA_OUT <= cur_wdata;
            // Never drive during a read: the FPGA owns the data lines then
            BUS_DATA_OE_OUT <= !cur_read && bus_state inside {FHP_SETUP, FHP_STROBE, FHP_HOLD};
        end
    end

    fhp_shadow_mem u_shadow (
        .clk_in(CLK_IN),
        .we_in(mem_we),
        .waddr_in(cur_idx),
        .wdata_in(last_rd),
        .raddr_in(win_idx(araddr)),
        .rdata_out(mem_rdata)
    );

    // ------------------------------------------------------------
    // AXI4-Lite read side
    // ------------------------------------------------------------
    assign S_AXI_ARREADY_OUT = !rd_pend && !S_AXI_RVALID_OUT;
    assign S_AXI_RRESP_OUT = 2'h0;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_pend <= 1'b0;
            rd_done <= 1'b0;
            araddr <= '0;
            rd_from_mem <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= '0;
        end else begin
            rd_done <= 1'b0;
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
                rd_pend <= 1'b1;
                araddr <= S_AXI_ARADDR_IN;
                rd_from_mem <= is_win(S_AXI_ARADDR_IN);
            end
            if (rd_pend && !rd_done) begin
                rd_done <= 1'b1;
            end
            if (rd_done) begin
                rd_pend <= 1'b0;
                S_AXI_RVALID_OUT <= 1'b1;
                if (rd_from_mem) begin
                    S_AXI_RDATA_OUT <= {16'h0000, mem_rdata};
                end else begin
                    case (araddr)
                        FHP_REG_CTRL: S_AXI_RDATA_OUT <= {30'h0, osc_en, 1'b0};
                        FHP_REG_STATUS: begin
                            S_AXI_RDATA_OUT <= '0;
                            S_AXI_RDATA_OUT[FHP_ST_BUSY_BIT] <= bus_busy;
                            S_AXI_RDATA_OUT[FHP_ST_INIT_BIT] <= init_s;
                            S_AXI_RDATA_OUT[FHP_ST_DONE_BIT] <= done_s;
                            S_AXI_RDATA_OUT[FHP_ST_CFG_READY_BIT] <= cfg_state == FHP_CFG_READY;
                            S_AXI_RDATA_OUT[FHP_ST_IRQ_LSB +: 3] <= irq_s;
                            S_AXI_RDATA_OUT[FHP_ST_WAIT_BIT] <= cfg_state == FHP_CFG_WAIT;
                        end
                        FHP_REG_RDATA: S_AXI_RDATA_OUT <= {16'h0000, last_rd};
                        default: S_AXI_RDATA_OUT <= '0;
                    endcase
                end
            end else if (S_AXI_RREADY_IN) begin
                S_AXI_RVALID_OUT <= 1'b0;
            end
        end
    end
endmodule

// ### sim/fhp_host_port_props.sv
// Checker: async bus timing and program pulse
`timescale 1ns/1ps
module fhp_host_port_props import fhp_pkg::*; (
    input logic CLK_IN,
    input logic RST_B_IN,
    input logic FPGA_CHIP_SELECT_N_OUT,
    input logic BUS_WRITE_STROBE_N_OUT,
    input logic BUS_OUTPUT_ENABLE_N_OUT,
    input logic BUS_READ_NOT_WRITE_OUT,
    input logic [3:0] BUS_ADDR_OUT,
    input logic BANK_ADDR_BIT_OUT,
    input logic BUS_DATA_OE_OUT,
    input logic PROC_GPIO_PROGRAM_OUT,
    input logic S_AXI_RVALID_OUT,
    input logic S_AXI_RREADY_IN,
    input logic [31:0] S_AXI_RDATA_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic [7:0] low_cnt;
    // Saturated after reset: reset held the line low
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            low_cnt <= 8'hff;
        end else if (PROC_GPIO_PROGRAM_OUT) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    prog_pulse_a: assert property ($rose(PROC_GPIO_PROGRAM_OUT) |->
        low_cnt >= FHP_PROG_LOW_CYC) else $error("program pulse too short");
    cs_span_a: assert property ($fell(FPGA_CHIP_SELECT_N_OUT) |->
        !FPGA_CHIP_SELECT_N_OUT [*8] ##1 FPGA_CHIP_SELECT_N_OUT) else $error("select span wrong");
    wr_timing_a: assert property ($fell(FPGA_CHIP_SELECT_N_OUT) && !BUS_READ_NOT_WRITE_OUT |->
        BUS_WRITE_STROBE_N_OUT [*2] ##1 !BUS_WRITE_STROBE_N_OUT [*4] ##1 BUS_WRITE_STROBE_N_OUT)
        else $error("write phases wrong");
    rd_timing_a: assert property ($fell(FPGA_CHIP_SELECT_N_OUT) && BUS_READ_NOT_WRITE_OUT |->
        BUS_OUTPUT_ENABLE_N_OUT [*2] ##1 !BUS_OUTPUT_ENABLE_N_OUT [*4] ##1 BUS_OUTPUT_ENABLE_N_OUT)
        else $error("read phases wrong");
    we_qual_a: assert property (!BUS_WRITE_STROBE_N_OUT |->
        !FPGA_CHIP_SELECT_N_OUT && !BUS_READ_NOT_WRITE_OUT) else $error("write strobe unqualified");
    oe_qual_a: assert property (!BUS_OUTPUT_ENABLE_N_OUT |->
        !FPGA_CHIP_SELECT_N_OUT && BUS_READ_NOT_WRITE_OUT) else $error("output enable unqualified");
    drive_dir_a: assert property (BUS_DATA_OE_OUT |-> !BUS_READ_NOT_WRITE_OUT)
        else $error("data driven in a read");
    addr_hold_a: assert property (!FPGA_CHIP_SELECT_N_OUT && $past(!FPGA_CHIP_SELECT_N_OUT) |->
        $stable(BUS_ADDR_OUT) && $stable(BANK_ADDR_BIT_OUT)) else $error("index moved in access");
    rdata_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read answer dropped");
endmodule

bind fhp_host_port fhp_host_port_props chk_u (.*);

// ### sim/fhp_fpga_model.sv
// Model of the configured device; no configuration readback, register reads answered only while the oscillator is enabled
`timescale 1ns/1ps
module fhp_fpga_model #(
    parameter int CFG_BYTES = 4,
    parameter int INIT_DLY = 6
) (
    input logic clk_in,
    input logic program_n_in,
    input logic osc_en_in,
    input logic cs_n_in,
    input logic we_n_in,
    input logic oe_n_in,
    input logic rnw_in,
    input logic [3:0] addr_in,
    input logic bank_in,
    input logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_out,
    output logic init_out,
    output logic done_out,
    output logic [2:0] irq_out
);
    logic [15:0] mem [32];
    logic [7:0] cfg_cnt;
    logic [15:0] cfg_sum;
    logic [3:0] init_cnt;
    logic [4:0] idx;
    assign idx = {bank_in, addr_in};
    // Strobe rise is the capture point in both phases
    always_ff @(posedge we_n_in or negedge program_n_in) begin
        if (!program_n_in) begin
            cfg_cnt <= 8'h00;
            cfg_sum <= 16'h0000;
            irq_out <= 3'h0;
        end else if (!cs_n_in && !done_out) begin
            cfg_cnt <= cfg_cnt + 8'h01;
            cfg_sum <= cfg_sum + {8'h00, data_in[7:0]};
        end else if (!cs_n_in) begin
            mem[idx] <= data_in;
            if (idx == 5'h1f) begin
                irq_out <= data_in[2:0];
            end
        end
    end
    always_ff @(posedge clk_in or negedge program_n_in) begin
        if (!program_n_in) begin
            init_cnt <= 4'h0;
            init_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            if (init_cnt != INIT_DLY) begin
                init_cnt <= init_cnt + 4'h1;
            end else begin
                init_out <= 1'b1;
            end
            if (cfg_cnt == CFG_BYTES) begin
                done_out <= 1'b1;
            end
        end
    end
    // No oscillator, no answer
    assign data_oe_out = !cs_n_in && !oe_n_in && rnw_in && done_out && osc_en_in;
    assign data_out = mem[idx];
endmodule

// ### sim/tb_top.sv
// Bench of the host port controller
`timescale 1ns/1ps
module tb_top import fhp_pkg::*; ;
    typedef struct {string nm; logic [31:0] e, m;} fhp_note_t;
    fhp_note_t notes[$];
    fhp_note_t nt;
    int n_errors = 0, compares = 0, seed = 45665, cyc = 0;
    logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, r;
    logic awready, wready, bvalid, arready, rvalid, cs_n, we_n, oe_n, rnw, ba, d_oe, m_oe;
    logic prog, osc, init, done;
    logic [3:0] addr;
    logic [2:0] irq;
    logic [4:0] ix;
    logic [15:0] d_out, m_out, bus, v, sum;
    logic [15:0] bus_last = '0;
    // Undriven bus shows the inverse, never a stale value
    assign bus = m_oe ? m_out : (d_oe ? d_out : ~bus_last);
    always @(posedge clk) bus_last <= bus;
    always #5 clk = ~clk;
    fhp_host_port #(.INIT_WAIT_CYC(50)) dut_u (.CLK_IN(clk), .RST_B_IN(rst_b),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .FPGA_CHIP_SELECT_N_OUT(cs_n),
        .BUS_WRITE_STROBE_N_OUT(we_n), .BUS_OUTPUT_ENABLE_N_OUT(oe_n),
        .BUS_READ_NOT_WRITE_OUT(rnw), .BUS_ADDR_OUT(addr), .BANK_ADDR_BIT_OUT(ba),
        .BUS_DATA_IN(bus), .BUS_DATA_OUT(d_out), .BUS_DATA_OE_OUT(d_oe),
        .PROC_GPIO_PROGRAM_OUT(prog), .PROC_GPIO_INIT_IN(init), .PROC_GPIO_DONE_IN(done),
        .PROC_GPIO_OSC_ENABLE_OUT(osc), .PROC_IRQ_LINE_A_IN(irq[0]),
        .PROC_IRQ_LINE_B_IN(irq[1]), .PROC_IRQ_LINE_C_IN(irq[2]));
    fhp_fpga_model model_u (.clk_in(clk), .program_n_in(prog), .osc_en_in(osc), .cs_n_in(cs_n),
        .we_n_in(we_n), .oe_n_in(oe_n), .rnw_in(rnw), .addr_in(addr), .bank_in(ba),
        .data_in(bus), .data_out(m_out), .data_oe_out(m_oe), .init_out(init),
        .done_out(done), .irq_out(irq));
    // --------------------
    // Shared tasks and result monitor
    // --------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            end_sim();
        end
    end
    always @(posedge clk) begin
        if (rvalid && rready) begin
            nt = notes.pop_front();
            if (nt.m != 0) chk(nt.nm, nt.e & nt.m, rdata & nt.m);
        end
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv);
        logic ta, tw, bd;
        @(posedge clk);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            bd = bvalid === 1'b1;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!bd);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input string nm, input logic [31:0] e, m,
                          output logic [31:0] dv);
        notes.push_back('{nm, e, m});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        dv = rdata;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic poll(input int b, input logic want);
        logic [31:0] s;
        s = {32{~want}};
        while (s[b] !== want) axi_rd(FHP_REG_STATUS, "status", 0, 0, s);
    endtask
    // --------------------
    // Main sequence
    // --------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk);
        chk("program line", 1, 32'(prog));
        chk("osc enable", 0, 32'(osc));
        $display("reset test done");
        axi_wr(FHP_REG_CTRL, 32'h3);
        poll(FHP_ST_CFG_READY_BIT, 1'b1);
        axi_rd(FHP_REG_STATUS, "init bit", 32'h2, 32'h2, d);
        chk("osc enable", 1, 32'(osc));
        sum = 16'h0000;
        repeat (4) begin
            r = $random(seed);
            sum = sum + {8'h00, r[7:0]};
            axi_wr(FHP_REG_CFG_DATA, r);
        end
        poll(FHP_ST_DONE_BIT, 1'b1);
        chk("config sum", 32'(sum), 32'(model_u.cfg_sum));
        $display("config test done");
        for (int i = 0; i < 6; i++) begin
            ix = (i == 0) ? 5'h00 : (i == 5) ? 5'h1e : 5'($unsigned($random(seed)) % 31);
            v = 16'($random(seed));
            axi_wr(FHP_REG_WIN_BASE + {1'b0, ix, 2'b00}, 32'(v));
            axi_wr(FHP_REG_ACCESS, {7'h0, 1'b1, 3'h0, ix, 16'h0});
            poll(FHP_ST_BUSY_BIT, 1'b0);
            axi_rd(FHP_REG_RDATA, "rdata", 32'(v), 32'hffff, d);
            axi_rd(FHP_REG_WIN_BASE + {1'b0, ix, 2'b00}, "shadow", 32'(v), 32'hffff, d);
        end
        $display("register test done");
        for (int k = 1; k < 8; k += 3) begin
            axi_wr(FHP_REG_WIN_BASE + 8'h7c, 32'(k));
            poll(FHP_ST_BUSY_BIT, 1'b0);
            repeat (3) @(posedge clk);
            axi_rd(FHP_REG_STATUS, "irq lines", 32'(k) << 4, 32'h70, d);
        end
        axi_wr(8'h44, $random(seed));
        axi_rd(8'h40, "unmapped", 32'h0, 32'hffffffff, d);
        axi_rd(FHP_REG_CTRL, "ctrl osc", 32'h2, 32'h2, d);
        $display("irq test done");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(negedge clk);
        chk("program in reset", 0, 32'(prog));
        chk("osc in reset", 0, 32'(osc));
        @(posedge clk);
        rst_b <= 1'b1;
        axi_rd(FHP_REG_STATUS, "done after reset", 32'h0, 32'h4, d);
        $display("reset2 test done");
        end_sim();
    end
endmodule
